// ===== src/irq_ctrl_defs.vh
// constants for the three-group interrupt control block
`ifndef IRQ_CTRL_DEFS_VH
`define IRQ_CTRL_DEFS_VH
`define IRQ_CTRL_OFFSET 32'h0000_0004
`define IRQ_CTRL_RESET 12'h008
`define G0_SEL_LSB 0
`define G0_FLAG_BIT 3
`define G1_SEL_LSB 4
`define G1_FLAG_BIT 7
`define G2_SEL_LSB 8
`define G2_FLAG_BIT 11
`define SEL_IDLE 3'h0
`define SEL_CODE1 3'h1
`define SEL_CODE2 3'h2
`define SEL_CODE3 3'h3
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ===== src/edge_event_detect.v
// one-cycle rise and fall pulses from a same-clock level
`timescale 1ns/1ps
`default_nettype none
module edge_event_detect
(
    input wire clk, // system clock
    input wire rst_n, // synchronous reset, active low
    input wire level, // level to watch
    output wire rise, // low-to-high pulse
    output wire fall // high-to-low pulse
);
    reg prev;
    reg primed;

    // first cycle after reset only loads prev, so a level present at reset is no edge
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            prev <= 1'b0;
            primed <= 1'b0;
        end
        else
        begin
            prev <= level;
            primed <= 1'b1;
        end
    end

    assign rise = primed & level & ~prev;
    assign fall = primed & ~level & prev;
endmodule
`default_nettype wire

// ===== src/three_group_interrupt_control.v
// three-group interrupt control register with AXI4-Lite access
//
// What this block does
// R01: group zero select codes autocal, aux rise, fall
// R02: group zero select zero sets nothing
// R03: group zero flag set on selected condition
// R04: host writing zero clears flag and request
// R05: reset value reads 0000 0008h
// R06: group one select: threshold rise, fall
// R07: group one flag set and cleared likewise
// R08: group two select: threshold edges, burst done
// R09: group two flag set and cleared likewise
// R10: group one/two select zero sets nothing
// R11: conditions latched on edges, not levels
// R12: input threshold flag when count exceeds threshold
// R13: output threshold flag when count exceeds threshold
// R14: bits twelve upward read zero, ignore writes
// R15: interrupt output high while any flag set, from the first clock edge out of reset
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_defs.vh"
module three_group_interrupt_control
(
    input wire clk, // 20 MHz system clock
    input wire rst_n, // synchronous reset, active low
    input wire autocalDone, // autocal completion level, same clock
    input wire auxInputPin, // auxiliary input pin, asynchronous
    input wire [15:0] inBufCount, // words in input buffer
    input wire [14:0] inBufThreshold, // input buffer threshold value
    input wire [15:0] outBufCount, // words in output buffer
    input wire [14:0] outBufThreshold, // output buffer threshold value
    input wire outBurstDone, // output burst completion level, same clock
    output reg irqRequest, // interrupt toward host bridge
    output reg inThresholdFlag, // input buffer above threshold
    output reg outThresholdFlag, // output buffer above threshold
    input wire [31:0] s_axi_awaddr, // write address
    input wire s_axi_awvalid, // write address valid
    output reg s_axi_awready, // write address ready
    input wire [31:0] s_axi_wdata, // write data
    input wire [3:0] s_axi_wstrb, // write byte strobes
    input wire s_axi_wvalid, // write data valid
    output reg s_axi_wready, // write data ready
    output reg [1:0] s_axi_bresp, // write response
    output reg s_axi_bvalid, // write response valid
    input wire s_axi_bready, // write response ready
    input wire [31:0] s_axi_araddr, // read address
    input wire s_axi_arvalid, // read address valid
    output reg s_axi_arready, // read address ready
    output reg [31:0] s_axi_rdata, // read data
    output reg [1:0] s_axi_rresp, // read response
    output reg s_axi_rvalid, // read data valid
    input wire s_axi_rready // read data ready
);
    // picks the event for a 3-bit selector; code 0 and reserved codes give none
    function pick_event;
        input [2:0] sel;
        input e1;
        input e2;
        input e3;
        begin
            case (sel)
                `SEL_CODE1: pick_event = e1;
                `SEL_CODE2: pick_event = e2;
                `SEL_CODE3: pick_event = e3;
                default: pick_event = 1'b0;
            endcase
        end
    endfunction

    function addr_hit;
        input [31:0] addr;
        begin
            addr_hit = ({addr[31:2], 2'b00} == `IRQ_CTRL_OFFSET);
        end
    endfunction

    reg auxMeta;
    reg auxSync;
    reg [2:0] groupZeroConditionSelect;
    reg [2:0] groupOneConditionSelect;
    reg [2:0] groupTwoConditionSelect;
    reg groupZeroPendingFlag;
    reg groupOnePendingFlag;
    reg groupTwoPendingFlag;
    reg awHeld;
    reg wHeld;
    reg [31:0] wrAddr;
    reg [31:0] wrData;
    reg [3:0] wrStrb;
    wire autocalRise;
    wire auxRise;
    wire auxFall;
    wire inThrRise;
    wire inThrFall;
    wire outThrRise;
    wire outThrFall;
    wire burstRise;
    wire ev0;
    wire ev1;
    wire ev2;
    wire doWrite;
    wire wrHit;
    wire [31:0] regValue;
    reg next_flag0;
    reg next_flag1;
    reg next_flag2;

    // two-stage synchroniser for the aux pin
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            auxMeta <= 1'b0;
            auxSync <= 1'b0;
        end
        else
        begin
            auxMeta <= auxInputPin;
            auxSync <= auxMeta;
        end
    end

    // threshold comparators
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            inThresholdFlag <= 1'b0;
            outThresholdFlag <= 1'b0;
        end
        else
        begin
            inThresholdFlag <= (inBufCount > {1'b0, inBufThreshold}); // R12
            outThresholdFlag <= (outBufCount > {1'b0, outBufThreshold}); // R13
        end
    end

    // edge detection of every condition
    edge_event_detect u_autocal // R11
    (
        .clk(clk),
        .rst_n(rst_n),
        .level(autocalDone),
        .rise(autocalRise),
        .fall()
    );
    edge_event_detect u_aux
    (
        .clk(clk),
        .rst_n(rst_n),
        .level(auxSync),
        .rise(auxRise),
        .fall(auxFall)
    );
    edge_event_detect u_inthr
    (
        .clk(clk),
        .rst_n(rst_n),
        .level(inThresholdFlag),
        .rise(inThrRise),
        .fall(inThrFall)
    );
    edge_event_detect u_outthr
    (
        .clk(clk),
        .rst_n(rst_n),
        .level(outThresholdFlag),
        .rise(outThrRise),
        .fall(outThrFall)
    );
    edge_event_detect u_burst
    (
        .clk(clk),
        .rst_n(rst_n),
        .level(outBurstDone),
        .rise(burstRise),
        .fall()
    );

    assign ev0 = pick_event(groupZeroConditionSelect, autocalRise, auxRise, auxFall); // R01 R02
    assign ev1 = pick_event(groupOneConditionSelect, inThrRise, inThrFall, 1'b0); // R06 R10
    assign ev2 = pick_event(groupTwoConditionSelect, outThrRise, outThrFall, burstRise); // R08 R10

    assign doWrite = awHeld & wHeld & ~s_axi_bvalid;
    assign wrHit = addr_hit(wrAddr);
    assign regValue = {20'h0_0000, groupTwoPendingFlag, groupTwoConditionSelect, // R14
        groupOnePendingFlag, groupOneConditionSelect,
        groupZeroPendingFlag, groupZeroConditionSelect};

    // flag next values: hardware set wins over host clear
    always @*
    begin
        next_flag0 = groupZeroPendingFlag;
        next_flag1 = groupOnePendingFlag;
        next_flag2 = groupTwoPendingFlag;
        if (doWrite && wrHit && wrStrb[0])
        begin
            next_flag0 = wrData[`G0_FLAG_BIT]; // R04
            next_flag1 = wrData[`G1_FLAG_BIT]; // R04
        end
        if (doWrite && wrHit && wrStrb[1])
            next_flag2 = wrData[`G2_FLAG_BIT]; // R04
        if (ev0)
            next_flag0 = 1'b1; // R03
        if (ev1)
            next_flag1 = 1'b1; // R07
        if (ev2)
            next_flag2 = 1'b1; // R09
    end

    // control register and interrupt output
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            groupZeroConditionSelect <= `SEL_IDLE; // R05
            groupOneConditionSelect <= `SEL_IDLE;
            groupTwoConditionSelect <= `SEL_IDLE;
            groupZeroPendingFlag <= 1'b1; // R05
            groupOnePendingFlag <= 1'b0;
            groupTwoPendingFlag <= 1'b0;
            irqRequest <= 1'b0;
        end
        else
        begin
            if (doWrite && wrHit && wrStrb[0])
            begin
                groupZeroConditionSelect <= wrData[`G0_SEL_LSB +: 3];
                groupOneConditionSelect <= wrData[`G1_SEL_LSB +: 3];
            end
            if (doWrite && wrHit && wrStrb[1])
                groupTwoConditionSelect <= wrData[`G2_SEL_LSB +: 3];
            groupZeroPendingFlag <= next_flag0;
            groupOnePendingFlag <= next_flag1;
            groupTwoPendingFlag <= next_flag2;
            irqRequest <= next_flag0 | next_flag1 | next_flag2; // R15 R04
        end
    end

    // write channels: address and data taken in either order
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            wrAddr <= 32'h0000_0000;
            wrData <= 32'h0000_0000;
            wrStrb <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                awHeld <= 1'b1;
                wrAddr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wHeld <= 1'b1;
                wrData <= s_axi_wdata;
                wrStrb <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (doWrite)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wrHit ? `RESP_OKAY : `RESP_SLVERR;
                awHeld <= 1'b0;
                wHeld <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // read channel
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= addr_hit(s_axi_araddr) ? regValue : 32'h0000_0000;
            s_axi_rresp <= addr_hit(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// ===== verif/irq_ctrl_monitor.sv
// assertion checker for the interrupt control block
`timescale 1ns/1ps
`default_nettype none
module irq_ctrl_monitor
(
    input wire logic clk, // clock
    input wire logic rst_n, // reset
    input wire logic irqRequest, // irq
    input wire logic inThresholdFlag, // in flag
    input wire logic outThresholdFlag, // out flag
    input wire logic [15:0] inBufCount, // in count
    input wire logic [14:0] inBufThreshold, // in limit
    input wire logic [15:0] outBufCount, // out count
    input wire logic [14:0] outBufThreshold, // out limit
    input wire logic s_axi_awvalid, // aw
    input wire logic s_axi_awready, // aw
    input wire logic s_axi_wvalid, // w
    input wire logic s_axi_wready, // w
    input wire logic s_axi_bvalid, // b
    input wire logic s_axi_arvalid, // ar
    input wire logic s_axi_arready, // ar
    input wire logic [31:0] s_axi_araddr, // ar
    input wire logic s_axi_rvalid, // r
    input wire logic [1:0] s_axi_rresp, // r
    input wire logic [31:0] s_axi_rdata // r
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    a_reset_flag: assert property (rst_n && !$past(rst_n) |-> ##[1:2] irqRequest)
        else $error("irq not set after reset");
    a_in_thresh: assert property ($past(rst_n) |-> inThresholdFlag ==
        ($past(inBufCount) > {1'b0, $past(inBufThreshold)})) else $error("in flag wrong");
    a_out_thresh: assert property ($past(rst_n) |-> outThresholdFlag ==
        ($past(outBufCount) > {1'b0, $past(outBufThreshold)})) else $error("out flag wrong");
    a_write_resp: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> !s_axi_awready ##1 (s_axi_bvalid && !s_axi_awready)) else $error("bad write");
    a_read_resp: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid && !s_axi_arready) else $error("bad read");
    a_bad_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[31:2] != 1
        |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0000_0000) else $error("bad addr");
    a_good_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[31:2] == 1
        |=> s_axi_rresp == 2'h0) else $error("read not okay");
    a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:12] == 20'h0_0000)
        else $error("upper bits set");
    cover property ($rose(irqRequest));
    cover property ($rose(inThresholdFlag));
    cover property ($rose(outThresholdFlag));
endmodule
`default_nettype wire

// ===== verif/host_irq_sink.sv
// host-side sink counting interrupt request edges
`timescale 1ns/1ps
`default_nettype none
module host_irq_sink
(
    input wire logic clk, // clock
    input wire logic irqRequest, // request line
    output wire logic [7:0] riseCount // edges seen
);
    logic last = 1'b0;
    logic [7:0] count = 8'h00;
    assign riseCount = count;
    always @(posedge clk)
    begin
        last <= irqRequest;
        if (irqRequest === 1'b1 && last === 1'b0)
            count <= count + 8'h01;
    end
endmodule
`default_nettype wire

// ===== verif/three_group_interrupt_control_tb.sv
// self-checking bench for the interrupt control block
`timescale 1ns/1ps
`default_nettype none
module three_group_interrupt_control_tb;
    logic clk, rst_n, autocalDone, auxInputPin, outBurstDone, irqRequest;
    logic inThresholdFlag, outThresholdFlag;
    logic [15:0] inBufCount, outBufCount;
    logic [14:0] inBufThreshold, outBufThreshold;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, data;
    logic [3:0] s_axi_wstrb;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [7:0] riseCount;
    integer miscompares, samples_checked, g, c, k, hit;
    three_group_interrupt_control u_three_group_interrupt_control (.*);
    host_irq_sink u_host_irq_sink (.clk(clk), .irqRequest(irqRequest), .riseCount(riseCount));
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task print_verdict;
    begin
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    end
    endtask
    task chk(input string n, input [31:0] e, input [31:0] v);
    begin
        samples_checked = samples_checked + 1;
        if (v !== e)
        begin
            miscompares = miscompares + 1;
            $display("wrong value %s exp %h got %h", n, e, v);
        end
    end
    endtask
    task acc(input logic wr, input [31:0] a, input [31:0] d);
        integer n;
    begin
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= {wr, wr, !wr};
        {s_axi_bready, s_axi_rready} <= {wr, !wr};
        n = 0;
        do
        begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            n = n + 1;
            if (n > 40) miscompares = miscompares + 1;
            if (n > 40) print_verdict;
        end while (!(wr ? s_axi_bvalid : s_axi_rvalid));
        {s_axi_bready, s_axi_rready} <= 2'b00;
        data = s_axi_rdata;
        resp = wr ? s_axi_bresp : s_axi_rresp;
    end
    endtask
    // one condition change per call, k 0 and 7 a one-cycle pulse; the sequence 0..7 returns all levels low
    task fire(input integer k);
    begin
        @(posedge clk);
        case (k)
            0: autocalDone <= 1'b1;
            1: auxInputPin <= 1'b1;
            2: auxInputPin <= 1'b0;
            3: inBufCount <= 16'h0011;
            4: inBufCount <= 16'h0010;
            5: outBufCount <= 16'h0011;
            6: outBufCount <= 16'h0010;
            default: outBurstDone <= 1'b1;
        endcase
        @(posedge clk);
        {autocalDone, outBurstDone} <= 2'b00;
        repeat (6) @(posedge clk);
    end
    endtask
    function integer want(input integer g, input integer c);
    begin
        want = -1;
        if (g == 0 && c >= 1 && c <= 3) want = c - 1;
        if (g == 1 && c >= 1 && c <= 2) want = c + 2;
        if (g == 2 && c >= 1 && c <= 3) want = c + 4;
    end
    endfunction
    initial
    begin
        miscompares = 0;
        samples_checked = 0;
        {rst_n, autocalDone, auxInputPin, outBurstDone, s_axi_awvalid} = 5'h00;
        {s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 4'h0;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
        {inBufCount, outBufCount} = {16'h0010, 16'h0010};
        {inBufThreshold, outBufThreshold} = {15'h0010, 15'h0010};
        s_axi_wstrb = 4'hf;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        acc(1'b0, 32'h0000_0004, 32'h0000_0000);
        chk("reset value", 32'h0000_0008, data);
        chk("reset irq", 32'h0000_0001, irqRequest);
        acc(1'b0, 32'h0000_0008, 32'h0000_0000);
        chk("unmapped read", 32'h0000_0002, resp);
        acc(1'b1, 32'h0000_0008, 32'h0000_0000);
        chk("unmapped write", 32'h0000_0002, resp);
        acc(1'b1, 32'h0000_0004, 32'hffff_f000);
        acc(1'b0, 32'h0000_0004, 32'h0000_0000);
        chk("upper bits", 32'h0000_0000, data);
        chk("irq cleared", 32'h0000_0000, irqRequest);
        $display("test basic done");
        for (g = 0; g < 3; g = g + 1)
            for (c = 0; c < 5; c = c + 1)
                for (k = 0; k < 8; k = k + 1)
                begin
                    acc(1'b1, 32'h0000_0004, c << (4 * g));
                    fire(k);
                    hit = (want(g, c) == k);
                    acc(1'b0, 32'h0000_0004, 32'h0000_0000);
                    chk("flags", (c << (4 * g)) | (hit << (4 * g + 3)), data);
                    chk("irq", hit, irqRequest);
                end
        $display("test groups done");
        chk("irq rises", 32'h0000_0009, riseCount);
        print_verdict;
    end
endmodule
bind three_group_interrupt_control irq_ctrl_monitor u_irq_ctrl_monitor (.*);
`default_nettype wire
